// ===== u4cfg_pkg.sv
// Package: register map, field layout, reset values and carriers for u4cfg
`default_nettype none
package u4cfg_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_PORT_ENABLE      = 10'h030;
	localparam logic [9:0] IDX_BASE_UPPER       = 10'h060;
	localparam logic [9:0] IDX_BASE_LOWER       = 10'h061;
	localparam logic [9:0] IDX_IRQ_CHANNEL      = 10'h070;
	localparam logic [9:0] IDX_LINE_MODE_CLOCK  = 10'h0f0;
	localparam logic [9:0] IDX_SLAVE_ADDRESS    = 10'h0f4;
	localparam logic [9:0] IDX_SLAVE_MASK       = 10'h0f5;
	localparam logic [9:0] IDX_ADDRESS_WAIT     = 10'h0f8;
	localparam logic [9:0] IDX_EVENT_STATUS     = 10'h0f9;
	localparam logic [9:0] IDX_EVENT_MASK       = 10'h0fa;

	// Field positions
	localparam int POS_PORT_ENABLE   = 0;
	localparam int POS_SHARE_ENABLE  = 4;
	localparam int POS_SHARE_STYLE   = 5;
	localparam int POS_NINE_BIT      = 7;
	localparam int POS_AUTO_ADDRESS  = 6;
	localparam int POS_RTS_INVERT    = 5;
	localparam int POS_HALF_DUPLEX   = 4;
	localparam int POS_ADDRESS_WAIT  = 0;

	// Strap-derived power-on values
	localparam logic [7:0] STRAP_BASE_UPPER = 8'h02;
	localparam logic [7:0] STRAP_BASE_LOWER = 8'he8;
	localparam logic [3:0] STRAP_IRQ_CHAN   = 4'h9;
	localparam logic [7:0] RESET_BYTE       = 8'h00;
	localparam logic [1:0] STRAP_LOAD_CYCLE = 2'h2;

	// Event status bits
	localparam int EV_GIVEN_HIT   = 0;
	localparam int EV_BCAST_HIT   = 1;
	localparam int EV_DISCARD     = 2;
	localparam int EV_DATA        = 3;
	localparam int EV_COUNT       = 4;

	// Clock source encodings
	localparam logic [1:0] CLK_SRC_1M8462 = 2'h0;
	localparam logic [1:0] CLK_SRC_18M    = 2'h1;
	localparam logic [1:0] CLK_SRC_24M    = 2'h2;
	localparam logic [1:0] CLK_SRC_14M    = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Received frame from the serial engine
	typedef struct packed {
		logic       ninth;
		logic [7:0] data;
	} u4cfg_frame_type;

	// Line mode and clock control register
	typedef struct packed {
		logic       nine_bit_mode_enable;
		logic       automatic_addressing_enable;
		logic       rts_invert;
		logic       half_duplex_line_mode;
		logic [1:0] dummy;
		logic       clock_source_select_high;
		logic       clock_source_select_low;
	} u4cfg_line_type;

endpackage : u4cfg_pkg
`default_nettype wire

// ===== u4cfg_top.sv
// Configuration registers and nine-bit address match for the fourth port
//
// Functional notes
// [RULE_01] Enable bit 0 powers up from strap; software may change it.
// [RULE_02] Base address upper byte powers up 0x02 if strap high, else 0x00.
// [RULE_03] Base address lower byte powers up 0xE8 if strap high, else 0x00.
// [RULE_04] Interrupt channel bits 3-0 power up 0x9 with strap high, else 0.
// [RULE_05] Bit 4 selects dedicated (0) or shared (1) interrupt line.
// [RULE_06] Bit 5 selects PCI or ISA sharing; effective only while sharing.
// [RULE_07] Nine-bit mode uses the parity position as address/data marker.
// [RULE_08] Without automatic addressing, software clears address-wait.
// [RULE_09] Auto addressing clears address-wait on a given or broadcast hit.
// [RULE_10] Port answers both the given and the broadcast address.
// [RULE_11] Given address: zero mask bits are don't-care, rest match address.
// [RULE_12] Broadcast: OR of address and mask; its one bits must be one.
// [RULE_13] Half-duplex mode drives request-to-send low when receiving.
// [RULE_14] Inversion bit flips request-to-send polarity in half-duplex mode.
// [RULE_15] Two-bit field selects port clock 1.8462, 18, 24 or 14 MHz.
// [RULE_16] Slave address resets to 00h and defines recognised addresses.
// [RULE_17] Only frames marked address by the ninth bit are matched.
// [RULE_18] Data frames are discarded while the address-wait flag is set.
`timescale 1ns/1ps
`default_nettype none
module u4cfg_top
	import u4cfg_pkg::*;
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// AXI4-Lite write address and data
	input  wire logic [11:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output var  logic             s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output var  logic             s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]       s_axi_bresp,
	output var  logic             s_axi_bvalid,
	input  wire logic             s_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output var  logic             s_axi_arready,
	output var  logic [31:0]      s_axi_rdata,
	output var  logic [1:0]       s_axi_rresp,
	output var  logic             s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// Strap pin
	input  wire logic             serial_out_strap_pin,
	// Receive frames from the serial engine
	input  wire logic             rx_frame_valid,
	input  wire u4cfg_frame_type  rx_frame,
	output var  logic             rx_data_valid,
	output var  logic [7:0]       rx_data,
	// Line direction
	input  wire logic             rx_required,
	input  wire logic             modem_rts_n,
	output var  logic             rts_out_n,
	// Configuration outputs
	output var  logic             port_enable_bit,
	output var  logic [7:0]       base_address_upper_byte,
	output var  logic [7:0]       base_address_lower_byte,
	output var  logic [3:0]       interrupt_channel_field,
	output var  logic             interrupt_sharing_enable,
	output var  logic             sharing_style_select,
	output var  u4cfg_line_type   line_control,
	output var  logic [7:0]       slave_address_value,
	output var  logic [7:0]       slave_address_mask,
	output var  logic             receive_address_wait_flag,
	// Interrupt
	output var  logic             irq
);

	// Strap capture and bus state
	logic                strap_sync1;
	logic                strap_sync2;
	logic [1:0]          load_count;
	logic                strap_load;
	logic                aw_held;
	logic                w_held;
	logic [9:0]          w_index;
	logic [7:0]          w_byte;
	logic                w_lane0;
	logic                do_write;
	logic                wr_en;
	logic                next_aw_held;
	logic                next_w_held;
	logic                next_bvalid;
	logic                next_rvalid;
	logic                ar_take;
	logic [7:0]          rd_byte;
	logic                rd_hit;
	logic [EV_COUNT-1:0] event_status;
	logic [EV_COUNT-1:0] event_mask;
	logic [EV_COUNT-1:0] event_set;
	// Address match and receive path
	logic [7:0]          bcast_pattern;
	logic                given_hit;
	logic                bcast_hit;
	logic                frame_take;
	logic                addr_frame;
	logic                deliver;
	logic                discard;
	logic                hw_wait_clear;

	// Strap passes two flops; it is caught once, a little after release
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_sync1 <= 1'b0;
			strap_sync2 <= 1'b0;
		end else begin
			// Only the second stage is read by the load logic
			strap_sync1 <= serial_out_strap_pin;
			strap_sync2 <= strap_sync1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			load_count <= 2'h0;
		end else if (load_count != 2'h3) begin
			load_count <= load_count + 2'h1;
		end
	end

	// Counter parks at its top, so the strap loads once per reset
	assign strap_load = (load_count == STRAP_LOAD_CYCLE);

	// AXI4-Lite write path; address and data may arrive in either order
	// Each ready stays low while its own half is held or a response waits
	assign do_write     = aw_held & w_held & ~s_axi_bvalid;
	assign next_aw_held = (aw_held | (s_axi_awvalid & s_axi_awready))
		& ~do_write;
	assign next_w_held  = (w_held | (s_axi_wvalid & s_axi_wready))
		& ~do_write;
	assign next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);
	assign wr_en        = do_write & w_lane0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			w_index       <= 10'h000;
			w_byte        <= 8'h00;
			w_lane0       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			s_axi_awready <= ~next_aw_held & ~next_bvalid;
			s_axi_wready  <= ~next_w_held & ~next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				w_index <= s_axi_awaddr[11:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_byte  <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (do_write) begin
				s_axi_bresp <= index_known(w_index) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Unmapped indices answer with an error and change nothing
	function automatic logic index_known(input logic [9:0] idx);
		case (idx)
			IDX_PORT_ENABLE, IDX_BASE_UPPER, IDX_BASE_LOWER, IDX_IRQ_CHANNEL,
			IDX_LINE_MODE_CLOCK, IDX_SLAVE_ADDRESS, IDX_SLAVE_MASK,
			IDX_ADDRESS_WAIT, IDX_EVENT_STATUS, IDX_EVENT_MASK:
				index_known = 1'b1;
			default:
				index_known = 1'b0;
		endcase
	endfunction : index_known

	// Configuration registers; a write can land as early as the strap load cycle
	// A write that lands in the load cycle is lost to the strap for the four strap-loaded fields only
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_enable_bit         <= 1'b0;
			base_address_upper_byte <= RESET_BYTE;
			base_address_lower_byte <= RESET_BYTE;
			interrupt_channel_field <= 4'h0;
		end else if (strap_load) begin
			port_enable_bit         <= strap_sync2;             // [RULE_01]
			base_address_upper_byte <= strap_sync2 ?
				STRAP_BASE_UPPER : RESET_BYTE;                  // [RULE_02]
			base_address_lower_byte <= strap_sync2 ?
				STRAP_BASE_LOWER : RESET_BYTE;                  // [RULE_03]
			interrupt_channel_field <= strap_sync2 ?
				STRAP_IRQ_CHAN : 4'h0;                          // [RULE_04]
		end else if (wr_en) begin
			case (w_index)
				IDX_PORT_ENABLE:
					port_enable_bit <= w_byte[POS_PORT_ENABLE];  // [RULE_01]
				IDX_BASE_UPPER:
					base_address_upper_byte <= w_byte;           // [RULE_02]
				IDX_BASE_LOWER:
					base_address_lower_byte <= w_byte;           // [RULE_03]
				IDX_IRQ_CHANNEL:
					interrupt_channel_field <= w_byte[3:0];      // [RULE_04]
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Plain fields take constants only; no strap here
			interrupt_sharing_enable <= 1'b0;
			sharing_style_select     <= 1'b0;
			line_control             <= '0;
			slave_address_value      <= RESET_BYTE;
			slave_address_mask       <= RESET_BYTE;
			event_mask               <= '0;
		end else if (wr_en) begin
			case (w_index)
				IDX_IRQ_CHANNEL: begin
					interrupt_sharing_enable <= w_byte[POS_SHARE_ENABLE]; // [RULE_05]
					sharing_style_select     <= w_byte[POS_SHARE_STYLE];  // [RULE_06]
				end
				IDX_LINE_MODE_CLOCK:
					line_control <= w_byte;      // [RULE_07] [RULE_13] [RULE_15]
				IDX_SLAVE_ADDRESS:
					slave_address_value <= w_byte;               // [RULE_16]
				IDX_SLAVE_MASK:
					slave_address_mask <= w_byte;
				IDX_EVENT_MASK:
					event_mask <= w_byte[EV_COUNT-1:0];
				default: begin
				end
			endcase
		end
	end

	// Address matching on received address frames
	assign bcast_pattern = slave_address_value | slave_address_mask; // [RULE_12]
	assign given_hit = ((rx_frame.data ^ slave_address_value)
		& slave_address_mask) == 8'h00;                            // [RULE_11]
	assign bcast_hit = (rx_frame.data & bcast_pattern)
		== bcast_pattern;                                          // [RULE_12]

	// A disabled port ignores every frame, address or data
	assign frame_take = rx_frame_valid & port_enable_bit;
	assign addr_frame = frame_take & line_control.nine_bit_mode_enable
		& rx_frame.ninth;                                          // [RULE_17]
	assign discard    = frame_take & line_control.nine_bit_mode_enable
		& ~rx_frame.ninth & receive_address_wait_flag;             // [RULE_18]
	assign deliver    = frame_take & ~addr_frame & ~discard;         // [RULE_07]
	// Without automatic addressing only software clears the flag
	assign hw_wait_clear = addr_frame
		& line_control.automatic_addressing_enable
		& (given_hit | bcast_hit);                      // [RULE_09] [RULE_10]

	// Software sets or clears the wait flag; a software set beats a match clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			receive_address_wait_flag <= 1'b0;
		end else if (wr_en && w_index == IDX_ADDRESS_WAIT) begin
			receive_address_wait_flag <= w_byte[POS_ADDRESS_WAIT]; // [RULE_08]
		end else if (hw_wait_clear) begin
			receive_address_wait_flag <= 1'b0;                     // [RULE_09]
		end
	end

	// Address frames and dropped data never reach the buffer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_valid <= 1'b0;
			rx_data       <= 8'h00;
		end else begin
			rx_data_valid <= deliver;                              // [RULE_18]
			if (deliver) begin
				rx_data <= rx_frame.data;
			end
		end
	end

	// Sticky events, write one to clear; a new event wins over the clear
	// Hits are logged on every address frame, automatic or not
	always_comb begin
		event_set               = '0;
		event_set[EV_GIVEN_HIT] = addr_frame & given_hit;          // [RULE_10]
		event_set[EV_BCAST_HIT] = addr_frame & bcast_hit;          // [RULE_10]
		event_set[EV_DISCARD]   = discard;
		event_set[EV_DATA]      = deliver;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_status <= '0;
		end else if (wr_en && w_index == IDX_EVENT_STATUS) begin
			event_status <= (event_status & ~w_byte[EV_COUNT-1:0]) | event_set;
		end else begin
			event_status <= event_status | event_set;
		end
	end

	// Registered level; it trails the status by one cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(event_status & event_mask);
		end
	end

	// Direction control; registered so the pin never glitches on decode
	// The cost is one cycle of lag behind the direction request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rts_out_n <= 1'b1;
		end else if (line_control.half_duplex_line_mode) begin
			rts_out_n <= line_control.rts_invert ? rx_required
				: ~rx_required;                         // [RULE_13] [RULE_14]
		end else begin
			rts_out_n <= modem_rts_n;
		end
	end

	// AXI4-Lite read path
	// One read at a time: arready stays low while data waits
	assign ar_take     = s_axi_arvalid & s_axi_arready;
	assign next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

	// Reserved bits read as zero except line mode bits 3-2, which read back as written; unmapped indices read zero
	always_comb begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		case (s_axi_araddr[11:2])
			IDX_PORT_ENABLE:     rd_byte = {7'h00, port_enable_bit};
			IDX_BASE_UPPER:      rd_byte = base_address_upper_byte;
			IDX_BASE_LOWER:      rd_byte = base_address_lower_byte;
			IDX_IRQ_CHANNEL:     rd_byte = {2'h0, sharing_style_select,
				interrupt_sharing_enable, interrupt_channel_field};
			IDX_LINE_MODE_CLOCK: rd_byte = line_control;
			IDX_SLAVE_ADDRESS:   rd_byte = slave_address_value;
			IDX_SLAVE_MASK:      rd_byte = slave_address_mask;
			IDX_ADDRESS_WAIT:    rd_byte = {7'h00, receive_address_wait_flag};
			IDX_EVENT_STATUS:    rd_byte = {4'h0, event_status};
			IDX_EVENT_MASK:      rd_byte = {4'h0, event_mask};
			default:             rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			// Data is captured at the take and held until rready
			if (ar_take) begin
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

endmodule : u4cfg_top
`default_nettype wire

// ===== u4cfg_properties.sv
// Checker: port-level properties of the u4cfg register block
`timescale 1ns/1ps
`default_nettype none
module u4cfg_checker
	import u4cfg_pkg::*;
(
	// Clock and reset
	input wire logic            sys_clk,
	input wire logic            rst_n,
	// Frames and delivery
	input wire logic            rx_frame_valid,
	input wire u4cfg_frame_type rx_frame,
	input wire logic            rx_data_valid,
	input wire logic [7:0]      rx_data,
	// Line direction
	input wire logic            rx_required,
	input wire logic            modem_rts_n,
	input wire logic            rts_out_n,
	// Configuration
	input wire logic            port_enable_bit,
	input wire u4cfg_line_type  line_control,
	input wire logic [7:0]      slave_address_value,
	input wire logic [7:0]      slave_address_mask,
	input wire logic            receive_address_wait_flag
);
	logic       take, nine, autoa, hit_given, hit_bcast, hd, inv;
	logic [7:0] bc;
	assign take = rx_frame_valid && port_enable_bit;
	assign nine = take && line_control.nine_bit_mode_enable;
	assign autoa = nine && line_control.automatic_addressing_enable
		&& rx_frame.ninth;
	assign bc = slave_address_value | slave_address_mask;
	assign hit_given = ((rx_frame.data ^ slave_address_value)
		& slave_address_mask) == 8'h00;
	assign hit_bcast = (rx_frame.data & bc) == bc;
	assign hd = line_control.half_duplex_line_mode;
	assign inv = line_control.rts_invert;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_given_clear;
		autoa && hit_given |=> !receive_address_wait_flag;
	endproperty
	a_given_clear: assert property (p_given_clear)
		else $error("Wait flag kept after given address hit");
	property p_bcast_clear;
		autoa && hit_bcast |-> ##1 !receive_address_wait_flag;
	endproperty
	a_bcast_clear: assert property (p_bcast_clear)
		else $error("Wait flag kept after broadcast hit");
	property p_drop_waiting;
		nine && !rx_frame.ninth && receive_address_wait_flag |=> !rx_data_valid;
	endproperty
	a_drop_waiting: assert property (p_drop_waiting)
		else $error("Data frame delivered while waiting for address");
	property p_addr_hidden;
		nine && rx_frame.ninth |=> !rx_data_valid;
	endproperty
	a_addr_hidden: assert property (p_addr_hidden)
		else $error("Address frame delivered as data");
	property p_normal_pass;
		take && !line_control.nine_bit_mode_enable
			|-> ##1 (rx_data_valid && rx_data == $past(rx_frame.data));
	endproperty
	a_normal_pass: assert property (p_normal_pass)
		else $error("Normal mode frame not delivered intact");
	property p_disabled;
		rx_frame_valid && !port_enable_bit |=> !rx_data_valid;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("Frame delivered while port disabled");
	property p_rts_hd;
		hd && !inv |=> rts_out_n == !$past(rx_required);
	endproperty
	a_rts_hd: assert property (p_rts_hd)
		else $error("Half duplex direction wrong");
	property p_rts_inv;
		hd && inv |=> rts_out_n == $past(rx_required);
	endproperty
	a_rts_inv: assert property (p_rts_inv)
		else $error("Inverted direction wrong");
	property p_rts_full;
		!hd |=> rts_out_n == $past(modem_rts_n);
	endproperty
	a_rts_full: assert property (p_rts_full)
		else $error("Full duplex direction not passed through");
	c_given: cover property (autoa && hit_given);
	c_bcast: cover property (autoa && hit_bcast && !hit_given);
	c_drop: cover property (nine && !rx_frame.ninth && receive_address_wait_flag);
endmodule : u4cfg_checker

bind u4cfg_top u4cfg_checker chk (.sys_clk, .rst_n, .rx_frame_valid,
	.rx_frame, .rx_data_valid, .rx_data, .rx_required, .modem_rts_n,
	.rts_out_n, .port_enable_bit, .line_control, .slave_address_value,
	.slave_address_mask, .receive_address_wait_flag);
`default_nettype wire

// ===== u4cfg_node.sv
// Model of a far node on the multi-drop line that sends frames
`timescale 1ns/1ps
`default_nettype none
module u4cfg_node
	import u4cfg_pkg::*;
(
	// Clock
	input  wire logic            sys_clk,
	// Frames toward the port
	output var  logic            rx_frame_valid,
	output var  u4cfg_frame_type rx_frame
);
	initial begin
		rx_frame_valid = 1'b0;
		rx_frame = 9'h000;
	end
	// Gap lets a test mix prompt and slow senders
	task automatic send(input logic nin, input logic [7:0] d, input int gap);
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		rx_frame_valid <= 1'b1;
		rx_frame <= {nin, d};
		@(posedge sys_clk);
		rx_frame_valid <= 1'b0;
		// Released line shows no stale frame
		rx_frame <= {~nin, ~d};
	endtask : send
endmodule : u4cfg_node
`default_nettype wire

// ===== tb_top.sv
// Testbench: register access, line direction and nine-bit address match
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import u4cfg_pkg::*;
;
	logic sys_clk = 1'b0, rst_n = 1'b0, serial_out_strap_pin = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic rx_required = 1'b0, modem_rts_n = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, rx_frame_valid, rx_data_valid, rts_out_n, irq;
	logic port_enable_bit, interrupt_sharing_enable, sharing_style_select;
	logic receive_address_wait_flag;
	logic [7:0] rx_data, base_address_upper_byte, base_address_lower_byte;
	logic [7:0] slave_address_value, slave_address_mask, cfg;
	logic [3:0] interrupt_channel_field;
	u4cfg_frame_type rx_frame;
	u4cfg_line_type line_control;
	int err_total = 0;
	int tests_run = 0;

	always #10 sys_clk = ~sys_clk;

	u4cfg_top uut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_out_strap_pin,
		.rx_frame_valid, .rx_frame, .rx_data_valid, .rx_data, .rx_required,
		.modem_rts_n, .rts_out_n, .port_enable_bit, .base_address_upper_byte,
		.base_address_lower_byte, .interrupt_channel_field,
		.interrupt_sharing_enable, .sharing_style_select, .line_control,
		.slave_address_value, .slave_address_mask,
		.receive_address_wait_flag, .irq);
	u4cfg_node u_node (.sys_clk, .rx_frame_valid, .rx_frame);

	task automatic end_of_test;
		$display("Counts: %0d compared, %0d mismatched", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tmo(input logic ok);
		if (!ok) begin
			err_total++;
			end_of_test();
		end
	endtask : tmo

	task automatic wr(input logic [9:0] i, input logic [7:0] d,
		input logic [1:0] er);
		logic a, w, b;
		logic [1:0] r;
		@(posedge sys_clk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		// Sample at the falling edge, act at the rising edge that takes it
		for (int n = 0; n < 40 && !b; n++) begin
			@(negedge sys_clk);
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge sys_clk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		tmo(b);
		chk("bresp", er, r);
	endtask : wr

	task automatic rd(input logic [9:0] i, input logic [7:0] e,
		input logic [1:0] er);
		logic a, v;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge sys_clk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		v = 1'b0;
		for (int n = 0; n < 40 && !v; n++) begin
			@(negedge sys_clk);
			a = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge sys_clk);
			if (a) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		tmo(v);
		chk("rdata", {24'h000000, e}, d);
		chk("rresp", er, r);
	endtask : rd

	task automatic frm(input logic nin, input logic [7:0] d, input logic ev);
		u_node.send(nin, d, int'(d[1:0]));
		@(negedge sys_clk);
		chk("rx_data_valid", ev, rx_data_valid);
		if (ev) chk("rx_data", d, rx_data);
	endtask : frm

	initial begin
		#1000000;
		err_total++;
		end_of_test();
	end

	initial begin
		for (int s = 0; s < 2; s++) begin
			serial_out_strap_pin <= s[0];
			rst_n <= 1'b0;
			repeat (10) @(posedge sys_clk);
			rst_n <= 1'b1;
			repeat (6) @(posedge sys_clk);
			rd(IDX_PORT_ENABLE, {7'h00, s[0]}, RESP_OKAY);
			rd(IDX_BASE_UPPER, s ? 8'h02 : 8'h00, RESP_OKAY);
			rd(IDX_BASE_LOWER, s ? 8'he8 : 8'h00, RESP_OKAY);
			rd(IDX_IRQ_CHANNEL, s ? 8'h09 : 8'h00, RESP_OKAY);
			rd(IDX_LINE_MODE_CLOCK, 8'h00, RESP_OKAY);
			rd(IDX_SLAVE_ADDRESS, 8'h00, RESP_OKAY);
		end
		$display("Test strap_defaults done");
		wr(IDX_IRQ_CHANNEL, 8'h3a, RESP_OKAY);
		rd(IDX_IRQ_CHANNEL, 8'h3a, RESP_OKAY);
		chk("share", 2'b11, {interrupt_sharing_enable, sharing_style_select});
		wr(IDX_BASE_UPPER, 8'h5a, RESP_OKAY);
		chk("base_upper", 8'h5a, base_address_upper_byte);
		wr(IDX_BASE_LOWER, 8'ha5, RESP_OKAY);
		chk("base_lower", 8'ha5, base_address_lower_byte);
		s_axi_wstrb <= 4'h0;
		wr(IDX_BASE_LOWER, 8'h11, RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		chk("lane0_off", 8'ha5, base_address_lower_byte);
		for (int k = 0; k < 4; k++) begin
			wr(IDX_LINE_MODE_CLOCK, {6'h00, k[1:0]}, RESP_OKAY);
			chk("clksel", k[1:0], line_control[1:0]);
		end
		wr(10'h100, 8'hff, RESP_SLVERR);
		rd(10'h100, 8'h00, RESP_SLVERR);
		wr(IDX_PORT_ENABLE, 8'h00, RESP_OKAY);
		frm(1'b0, 8'h12, 1'b0);
		wr(IDX_PORT_ENABLE, 8'h01, RESP_OKAY);
		chk("enable", 1'b1, port_enable_bit);
		$display("Test registers done");
		for (int c = 0; c < 6; c++) begin
			cfg = (c < 2) ? 8'h00 : (c < 4) ? 8'h10 : 8'h30;
			wr(IDX_LINE_MODE_CLOCK, cfg, RESP_OKAY);
			rx_required <= c[0];
			modem_rts_n <= c[0];
			@(posedge sys_clk);
			@(negedge sys_clk);
			chk("rts", cfg[4] && !cfg[5] ? c[0] ^ 1'b1 : c[0], rts_out_n);
		end
		$display("Test line_direction done");
		wr(IDX_SLAVE_ADDRESS, 8'h5c, RESP_OKAY);
		wr(IDX_SLAVE_MASK, 8'hf9, RESP_OKAY);
		rd(IDX_SLAVE_MASK, 8'hf9, RESP_OKAY);
		rd(IDX_SLAVE_ADDRESS, 8'h5c, RESP_OKAY);
		wr(IDX_LINE_MODE_CLOCK, 8'hc0, RESP_OKAY);
		wr(IDX_EVENT_STATUS, 8'h0f, RESP_OKAY);
		wr(IDX_ADDRESS_WAIT, 8'h01, RESP_OKAY);
		frm(1'b0, 8'h11, 1'b0);
		frm(1'b1, 8'h5a, 1'b0);
		rd(IDX_ADDRESS_WAIT, 8'h00, RESP_OKAY);
		frm(1'b0, 8'h22, 1'b1);
		rd(IDX_EVENT_STATUS, 8'h0d, RESP_OKAY);
		wr(IDX_EVENT_STATUS, 8'h0f, RESP_OKAY);
		wr(IDX_ADDRESS_WAIT, 8'h01, RESP_OKAY);
		frm(1'b1, 8'hff, 1'b0);
		rd(IDX_ADDRESS_WAIT, 8'h00, RESP_OKAY);
		rd(IDX_EVENT_STATUS, 8'h02, RESP_OKAY);
		wr(IDX_ADDRESS_WAIT, 8'h01, RESP_OKAY);
		frm(1'b1, 8'h5d, 1'b0);
		rd(IDX_ADDRESS_WAIT, 8'h01, RESP_OKAY);
		wr(IDX_LINE_MODE_CLOCK, 8'h80, RESP_OKAY);
		frm(1'b1, 8'h5a, 1'b0);
		rd(IDX_ADDRESS_WAIT, 8'h01, RESP_OKAY);
		wr(IDX_ADDRESS_WAIT, 8'h00, RESP_OKAY);
		frm(1'b0, 8'h33, 1'b1);
		$display("Test address_match done");
		wr(IDX_LINE_MODE_CLOCK, 8'h00, RESP_OKAY);
		wr(IDX_EVENT_STATUS, 8'h0f, RESP_OKAY);
		wr(IDX_EVENT_MASK, 8'h08, RESP_OKAY);
		frm(1'b1, 8'h44, 1'b1);
		@(negedge sys_clk);
		chk("irq", 1'b1, irq);
		wr(IDX_EVENT_STATUS, 8'h08, RESP_OKAY);
		@(negedge sys_clk);
		chk("irq", 1'b0, irq);
		wr(IDX_EVENT_MASK, 8'h00, RESP_OKAY);
		frm(1'b0, 8'h55, 1'b1);
		@(negedge sys_clk);
		chk("irq", 1'b0, irq);
		rd(IDX_EVENT_STATUS, 8'h08, RESP_OKAY);
		$display("Test interrupt done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
